/* File: src/amd_defines.svh */
`ifndef AMD_DEFINES_SVH
`define AMD_DEFINES_SVH

// prefix bytes that modify the following opcode
`define AMD_PFX_Y_BYTE 8'h90
`define AMD_PFX_YIND_BYTE 8'h91
`define AMD_PFX_IND_BYTE 8'h92

// opcode of the relative call that sits in the immediate row
`define AMD_OP_CALL_REL 8'had

// opcode row (upper nibble) groups
`define AMD_ROW_BITREL 4'h0
`define AMD_ROW_BIT 4'h1
`define AMD_ROW_REL 4'h2
`define AMD_ROW_DIR_RMW 4'h3
`define AMD_ROW_INH_A 4'h4
`define AMD_ROW_INH_X 4'h5
`define AMD_ROW_IDXS_RMW 4'h6
`define AMD_ROW_IDX0_RMW 4'h7
`define AMD_ROW_INH_M1 4'h8
`define AMD_ROW_INH_M2 4'h9
`define AMD_ROW_IMM 4'ha
`define AMD_ROW_DIR_S 4'hb
`define AMD_ROW_DIR_L 4'hc
`define AMD_ROW_IDX_L 4'hd
`define AMD_ROW_IDX_S 4'he
`define AMD_ROW_IDX0 4'hf

// upper byte of every page-zero address
`define AMD_PAGE0_HI 8'h00

// reset values
`define AMD_ADDR_RST 16'h0000
`define AMD_BYTE_RST 8'h00
`define AMD_LEN_RST 3'h0

`endif

/* File: src/amd_pkg.sv */
package amd_pkg;

    // seventeen operand addressing modes
    typedef enum logic [4:0] {
        AMD_INH, AMD_IMM, AMD_DIR_S, AMD_DIR_L,
        AMD_IDX_0, AMD_IDX_S, AMD_IDX_L,
        AMD_IND_S, AMD_IND_L, AMD_IIX_S, AMD_IIX_L,
        AMD_REL_D, AMD_REL_I, AMD_BIT_D, AMD_BIT_I,
        AMD_BITREL_D, AMD_BITREL_I
    } amd_mode_t;

    // prefix seen ahead of the opcode
    typedef enum logic [1:0] {
        AMD_PFX_NONE, AMD_PFX_Y, AMD_PFX_IND, AMD_PFX_YIND
    } amd_pfx_t;

    // fetch sequencer states
    typedef enum logic [2:0] {
        AMD_S_IDLE, AMD_S_OP, AMD_S_DEC, AMD_S_B1, AMD_S_B2,
        AMD_S_P1, AMD_S_P2, AMD_S_CALC
    } amd_state_t;

endpackage

/* File: src/amd_mode_decode.sv */
`timescale 1ns/100ps
`include "amd_defines.svh"

// opcode plus prefix to addressing mode, operand count and pointer needs
module amd_mode_decode (
    input wire logic [7:0] opcode, // byte under decode
    input wire amd_pkg::amd_pfx_t pfx, // prefix already taken
    output amd_pkg::amd_mode_t mode, // addressing mode
    output logic [1:0] n_bytes, // operand bytes after the opcode
    output logic ptr_rd, // pointer must be read from page zero
    output logic ptr_word, // pointer is a word, not a byte
    output logic use_y, // index register is y
    output logic is_prefix, // byte is a prefix, not an opcode
    output amd_pkg::amd_pfx_t new_pfx // prefix kind when is_prefix
);
    logic ind; // indirect prefix present

    // pure lookup on the opcode row and prefix
    always_comb begin
        ind = (pfx == amd_pkg::AMD_PFX_IND) || (pfx == amd_pkg::AMD_PFX_YIND);
        use_y = (pfx == amd_pkg::AMD_PFX_Y) || (pfx == amd_pkg::AMD_PFX_YIND);
        mode = amd_pkg::AMD_INH;
        n_bytes = 2'h0;
        ptr_word = 1'b0;
        is_prefix = 1'b0;
        new_pfx = amd_pkg::AMD_PFX_NONE;
        // a second prefix is not a prefix; it decodes as an opcode
        if (pfx == amd_pkg::AMD_PFX_NONE) begin
            if (opcode == `AMD_PFX_Y_BYTE) begin
                is_prefix = 1'b1;
                new_pfx = amd_pkg::AMD_PFX_Y;
            end else if (opcode == `AMD_PFX_IND_BYTE) begin
                is_prefix = 1'b1;
                new_pfx = amd_pkg::AMD_PFX_IND;
            end else if (opcode == `AMD_PFX_YIND_BYTE) begin
                is_prefix = 1'b1;
                new_pfx = amd_pkg::AMD_PFX_YIND;
            end
        end
        unique case (opcode[7:4])
            `AMD_ROW_BITREL: begin
                mode = ind ? amd_pkg::AMD_BITREL_I : amd_pkg::AMD_BITREL_D;
                n_bytes = 2'h2;
            end
            `AMD_ROW_BIT: begin
                mode = ind ? amd_pkg::AMD_BIT_I : amd_pkg::AMD_BIT_D;
                n_bytes = 2'h1;
            end
            `AMD_ROW_REL: begin
                mode = ind ? amd_pkg::AMD_REL_I : amd_pkg::AMD_REL_D;
                n_bytes = 2'h1;
            end
            // read-modify-write rows exist only in short forms
            `AMD_ROW_DIR_RMW, `AMD_ROW_DIR_S: begin
                mode = ind ? amd_pkg::AMD_IND_S : amd_pkg::AMD_DIR_S;
                n_bytes = 2'h1;
            end
            `AMD_ROW_IDXS_RMW, `AMD_ROW_IDX_S: begin
                mode = ind ? amd_pkg::AMD_IIX_S : amd_pkg::AMD_IDX_S;
                n_bytes = 2'h1;
            end
            `AMD_ROW_IDX0_RMW, `AMD_ROW_IDX0: begin
                mode = amd_pkg::AMD_IDX_0;
            end
            `AMD_ROW_IMM: begin
                if (opcode == `AMD_OP_CALL_REL) begin
                    mode = ind ? amd_pkg::AMD_REL_I : amd_pkg::AMD_REL_D;
                end else begin
                    mode = amd_pkg::AMD_IMM;
                end
                n_bytes = 2'h1;
            end
            // long indirect keeps only one byte after the opcode
            `AMD_ROW_DIR_L: begin
                mode = ind ? amd_pkg::AMD_IND_L : amd_pkg::AMD_DIR_L;
                n_bytes = ind ? 2'h1 : 2'h2;
                ptr_word = ind;
            end
            `AMD_ROW_IDX_L: begin
                mode = ind ? amd_pkg::AMD_IIX_L : amd_pkg::AMD_IDX_L;
                n_bytes = ind ? 2'h1 : 2'h2;
                ptr_word = ind;
            end
            default: begin // rows 4, 5, 8, 9: inherent
                mode = amd_pkg::AMD_INH;
            end
        endcase
        ptr_rd = ind && (mode != amd_pkg::AMD_IDX_0)
            && (mode != amd_pkg::AMD_INH) && (mode != amd_pkg::AMD_IMM);
    end

endmodule // amd_mode_decode

/* File: src/amd_addr_decoder.sv */
`timescale 1ns/100ps
`include "amd_defines.svh"

// Operation
// - seventeen addressing modes in seven groups
// - long forms reach all 64 Kbyte
// - short forms reach page zero, indexed ones up to 1fe
// - inherent instruction is one byte
// - inherent form decoded for listed operations
// - immediate is opcode plus one operand byte
// - immediate decoded for load, compare, arithmetic, logic
// - short direct fetches one address byte
// - long direct fetches two address bytes
// - indexed address is unsigned index plus offset
// - no-offset indexed fetches nothing, page zero
// - no-offset with y costs one prefix byte
// - short indexed spans 00 to 1fe
// - long indexed adds word offset, full space
// - indirect reads pointer at page-zero address
// - short indirect byte pointer, page zero
// - long indirect word pointer, one byte follows
// - indirect indexed adds index to pointer
// - short indirect indexed spans 00 to 1fe
// - branch target next pc minus 128..plus 127
// - prefix 90 switches x forms to y
// - prefix 92 switches to indirect forms
// - prefix 91 switches indirect x to y
module amd_addr_decoder (
    input wire logic clk, // core clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic start, // pulse: decode instruction at start_pc
    input wire logic [15:0] start_pc, // address of first instruction byte
    input wire logic [7:0] idx_x, // x index register
    input wire logic [7:0] idx_y, // y index register
    input wire logic [7:0] mem_rd_data, // memory read data
    input wire logic mem_rd_valid, // memory read data valid
    output logic mem_rd_req, // memory read request, held till valid
    output logic [15:0] mem_addr, // memory read address
    output logic busy, // sequence in progress
    output logic done, // pulse: results valid
    output amd_pkg::amd_mode_t mode_out, // decoded addressing mode
    output logic [7:0] opcode_out, // opcode byte
    output logic prefixed, // a prefix byte preceded the opcode
    output logic y_sel, // y index register in use
    output logic [2:0] instr_len, // instruction length in bytes
    output logic [15:0] next_pc, // address after the instruction
    output logic [15:0] eff_addr, // effective operand address
    output logic [7:0] operand, // immediate value or branch offset
    output logic [15:0] branch_target // relative branch destination
);
    amd_pkg::amd_state_t state; // sequencer state
    amd_pkg::amd_state_t next_state; // sequencer next state
    amd_pkg::amd_pfx_t pfx; // prefix taken so far
    logic [15:0] pc; // instruction start address
    logic [2:0] len; // bytes taken so far
    logic [7:0] opcode; // opcode byte
    logic [7:0] b1; // first byte after the opcode
    logic [7:0] b2; // second byte after the opcode
    logic [7:0] p1; // pointer byte, high byte for a word
    logic [7:0] p2; // pointer low byte
    logic [7:0] dec_in; // byte fed to the mode lookup
    amd_pkg::amd_mode_t dec_mode; // looked-up mode
    logic [1:0] dec_n; // looked-up operand count
    logic dec_ptr; // pointer read needed
    logic dec_word; // pointer is a word
    logic dec_y; // index is y
    logic dec_is_pfx; // byte is a prefix
    amd_pkg::amd_pfx_t dec_new_pfx; // kind of that prefix
    logic rd_ok; // read answered this cycle
    logic issue; // start a new read
    logic [15:0] issue_addr; // address of that read
    logic [15:0] pc_at; // address of the next unread instruction byte
    logic [15:0] npc; // address after the instruction
    logic [15:0] ptr16; // pointer contents
    logic [7:0] idx; // selected index register
    logic [15:0] next_ea; // effective address being formed
    logic [15:0] next_target; // branch target being formed
    logic [7:0] next_operand; // operand being formed

    // page-zero address of a byte
    function automatic logic [15:0] page0(input logic [7:0] a);
        page0 = {`AMD_PAGE0_HI, a};
    endfunction

    // unsigned index add, wrapping at 16 bits
    function automatic logic [15:0] add_index(input logic [15:0] base,
                                              input logic [7:0] ix);
        add_index = base + {8'h00, ix};
    endfunction

    // branch target from signed offset
    function automatic logic [15:0] rel_target(input logic [15:0] from,
                                               input logic [7:0] off);
        rel_target = from + {{8{off[7]}}, off};
    endfunction

    // while the opcode is in flight the lookup watches the bus
    assign dec_in = (state == amd_pkg::AMD_S_OP) ? mem_rd_data : opcode;

    amd_mode_decode u_mode_decode (
        .opcode(dec_in),
        .pfx(pfx),
        .mode(dec_mode),
        .n_bytes(dec_n),
        .ptr_rd(dec_ptr),
        .ptr_word(dec_word),
        .use_y(dec_y),
        .is_prefix(dec_is_pfx),
        .new_pfx(dec_new_pfx)
    );

    assign rd_ok = mem_rd_req && mem_rd_valid;
    assign pc_at = pc + {13'h0000, len};
    assign npc = pc_at;
    assign idx = dec_y ? idx_y : idx_x;
    assign ptr16 = dec_word ? {p1, p2} : page0(p1);

    // sequencer: opcode, operand bytes, then pointer bytes
    always_comb begin
        next_state = state;
        issue = 1'b0;
        issue_addr = mem_addr;
        unique case (state)
            amd_pkg::AMD_S_IDLE: if (start) begin
                next_state = amd_pkg::AMD_S_OP;
                issue = 1'b1;
                issue_addr = start_pc;
            end
            amd_pkg::AMD_S_OP: if (rd_ok) begin
                if (dec_is_pfx) begin // fetch the real opcode
                    issue = 1'b1;
                    issue_addr = pc_at + 16'h0001;
                end else begin
                    next_state = amd_pkg::AMD_S_DEC;
                end
            end
            amd_pkg::AMD_S_DEC: if (dec_n != 2'h0) begin
                next_state = amd_pkg::AMD_S_B1;
                issue = 1'b1;
                issue_addr = pc_at;
            end else begin
                next_state = amd_pkg::AMD_S_CALC;
            end
            amd_pkg::AMD_S_B1: if (rd_ok) begin
                if (dec_n == 2'h2) begin
                    next_state = amd_pkg::AMD_S_B2;
                    issue = 1'b1;
                    issue_addr = pc_at + 16'h0001;
                end else if (dec_ptr) begin
                    next_state = amd_pkg::AMD_S_P1;
                    issue = 1'b1;
                    issue_addr = page0(mem_rd_data);
                end else begin
                    next_state = amd_pkg::AMD_S_CALC;
                end
            end
            amd_pkg::AMD_S_B2: if (rd_ok) begin
                if (dec_ptr) begin // bit test indirect: pointer after offset
                    next_state = amd_pkg::AMD_S_P1;
                    issue = 1'b1;
                    issue_addr = page0(b1);
                end else begin
                    next_state = amd_pkg::AMD_S_CALC;
                end
            end
            amd_pkg::AMD_S_P1: if (rd_ok) begin
                if (dec_word) begin // low byte one address up
                    next_state = amd_pkg::AMD_S_P2;
                    issue = 1'b1;
                    issue_addr = page0(b1) + 16'h0001;
                end else begin
                    next_state = amd_pkg::AMD_S_CALC;
                end
            end
            amd_pkg::AMD_S_P2: if (rd_ok) begin
                next_state = amd_pkg::AMD_S_CALC;
            end
            amd_pkg::AMD_S_CALC: next_state = amd_pkg::AMD_S_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= amd_pkg::AMD_S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // memory port: one read outstanding, request held till answered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_rd_req <= 1'b0;
            mem_addr <= `AMD_ADDR_RST;
        end else if (issue) begin
            mem_rd_req <= 1'b1;
            mem_addr <= issue_addr;
        end else if (rd_ok) begin
            mem_rd_req <= 1'b0;
        end
    end

    // capture of prefix, opcode, operand and pointer bytes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pfx <= amd_pkg::AMD_PFX_NONE;
            pc <= `AMD_ADDR_RST;
            len <= `AMD_LEN_RST;
            opcode <= `AMD_BYTE_RST;
            b1 <= `AMD_BYTE_RST;
            b2 <= `AMD_BYTE_RST;
            p1 <= `AMD_BYTE_RST;
            p2 <= `AMD_BYTE_RST;
        end else begin
            unique case (state)
                amd_pkg::AMD_S_IDLE: if (start) begin
                    pc <= start_pc;
                    len <= `AMD_LEN_RST;
                    pfx <= amd_pkg::AMD_PFX_NONE;
                end
                amd_pkg::AMD_S_OP: if (rd_ok) begin
                    len <= len + 3'h1;
                    if (dec_is_pfx) begin
                        pfx <= dec_new_pfx;
                    end else begin
                        opcode <= mem_rd_data;
                    end
                end
                amd_pkg::AMD_S_B1: if (rd_ok) begin
                    len <= len + 3'h1;
                    b1 <= mem_rd_data;
                end
                amd_pkg::AMD_S_B2: if (rd_ok) begin
                    len <= len + 3'h1;
                    b2 <= mem_rd_data;
                end
                amd_pkg::AMD_S_P1: if (rd_ok) begin
                    p1 <= mem_rd_data;
                end
                amd_pkg::AMD_S_P2: if (rd_ok) begin
                    p2 <= mem_rd_data;
                end
                default: begin // decode and result states take no byte
                end
            endcase
        end
    end

    // effective address, branch target and operand per mode
    always_comb begin
        next_ea = `AMD_ADDR_RST;
        next_target = npc;
        next_operand = `AMD_BYTE_RST;
        unique case (dec_mode)
            amd_pkg::AMD_INH: next_ea = `AMD_ADDR_RST;
            amd_pkg::AMD_IMM: next_operand = b1;
            amd_pkg::AMD_DIR_S, amd_pkg::AMD_BIT_D: begin
                next_ea = page0(b1);
            end
            amd_pkg::AMD_DIR_L: next_ea = {b1, b2};
            amd_pkg::AMD_IDX_0: next_ea = page0(idx);
            amd_pkg::AMD_IDX_S: begin
                next_ea = add_index(page0(b1), idx);
            end
            amd_pkg::AMD_IDX_L: next_ea = add_index({b1, b2}, idx);
            amd_pkg::AMD_IND_S, amd_pkg::AMD_IND_L,
            amd_pkg::AMD_BIT_I: begin
                next_ea = ptr16;
            end
            amd_pkg::AMD_IIX_S, amd_pkg::AMD_IIX_L: begin
                next_ea = add_index(ptr16, idx);
            end
            amd_pkg::AMD_REL_D: begin
                next_operand = b1;
                next_target = rel_target(npc, b1);
            end
            amd_pkg::AMD_REL_I: begin
                next_operand = p1;
                next_target = rel_target(npc, p1);
            end
            amd_pkg::AMD_BITREL_D: begin
                next_ea = page0(b1);
                next_operand = b2;
                next_target = rel_target(npc, b2);
            end
            amd_pkg::AMD_BITREL_I: begin
                next_ea = ptr16;
                next_operand = b2;
                next_target = rel_target(npc, b2);
            end
        endcase
    end

    // result registers, loaded once per instruction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            busy <= 1'b0;
            mode_out <= amd_pkg::AMD_INH;
            opcode_out <= `AMD_BYTE_RST;
            prefixed <= 1'b0;
            y_sel <= 1'b0;
            instr_len <= `AMD_LEN_RST;
            next_pc <= `AMD_ADDR_RST;
            eff_addr <= `AMD_ADDR_RST;
            operand <= `AMD_BYTE_RST;
            branch_target <= `AMD_ADDR_RST;
        end else begin
            done <= (state == amd_pkg::AMD_S_CALC);
            busy <= (next_state != amd_pkg::AMD_S_IDLE);
            if (state == amd_pkg::AMD_S_CALC) begin
                mode_out <= dec_mode;
                opcode_out <= opcode;
                prefixed <= (pfx != amd_pkg::AMD_PFX_NONE);
                y_sel <= dec_y;
                instr_len <= len;
                next_pc <= npc;
                eff_addr <= next_ea;
                operand <= next_operand;
                branch_target <= next_target;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_INH_LEN: assert property (
        done && mode_out == amd_pkg::AMD_INH
        |-> instr_len == (prefixed ? 3'h2 : 3'h1))
        else $error("inherent length wrong");
    AST_IMM_LEN: assert property (
        done && mode_out == amd_pkg::AMD_IMM
        |-> instr_len == (prefixed ? 3'h3 : 3'h2))
        else $error("immediate length wrong");
    AST_SHORT_PAGE0: assert property (
        done && (mode_out == amd_pkg::AMD_DIR_S
            || mode_out == amd_pkg::AMD_IND_S
            || mode_out == amd_pkg::AMD_IDX_0)
        |-> eff_addr[15:8] == 8'h00)
        else $error("short form left page zero");
    AST_IDX0_LEN: assert property (
        done && mode_out == amd_pkg::AMD_IDX_0
        |-> instr_len == (y_sel ? 3'h2 : 3'h1))
        else $error("no-offset indexed length wrong");
    AST_SHORT_IDX_RANGE: assert property (
        done && (mode_out == amd_pkg::AMD_IDX_S
            || mode_out == amd_pkg::AMD_IIX_S)
        |-> eff_addr <= 16'h01fe)
        else $error("short indexed beyond 1fe");
    AST_LONG_IND_LEN: assert property (
        done && (mode_out == amd_pkg::AMD_IND_L
            || mode_out == amd_pkg::AMD_IIX_L)
        |-> instr_len == 3'h3)
        else $error("long indirect length wrong");
    AST_LONG_DIR_LEN: assert property (
        done && mode_out == amd_pkg::AMD_DIR_L
        |-> instr_len == (prefixed ? 3'h4 : 3'h3))
        else $error("long direct length wrong");
    AST_REL_RANGE: assert property (
        done && (mode_out == amd_pkg::AMD_REL_D
            || mode_out == amd_pkg::AMD_REL_I)
        |-> branch_target == next_pc + {{8{operand[7]}}, operand})
        else $error("branch target wrong");
    AST_REQ_HOLD: assert property (
        mem_rd_req && !mem_rd_valid
        |=> mem_rd_req && $stable(mem_addr))
        else $error("read request dropped early");
    AST_START_FETCH: assert property (
        start && state == amd_pkg::AMD_S_IDLE
        |=> mem_rd_req && mem_addr == $past(start_pc) ##0 busy)
        else $error("opcode fetch not started");
    AST_DONE_PULSE: assert property (
        done |-> !busy ##1 !done)
        else $error("done longer than one cycle");

    COV_IMM: cover property (done && mode_out == amd_pkg::AMD_IMM);
    COV_IIX_L: cover property (done && mode_out == amd_pkg::AMD_IIX_L);
    COV_BITREL_I: cover property (
        done && mode_out == amd_pkg::AMD_BITREL_I);
    COV_Y_PREFIX: cover property (done && prefixed && y_sel);

endmodule // amd_addr_decoder

/* File: tb/amd_mem_model.sv */
`timescale 1ns/100ps
// memory partner: answers each held read after a set number of waits
module amd_mem_model (
    input wire logic clk, // core clock
    input wire logic req, // read request, held till answered
    input wire logic [15:0] addr, // read address
    input wire logic [3:0] waits, // wait states before each answer
    output logic [7:0] data, // read data
    output logic valid // read data valid
);
    logic [7:0] mem [0:65535]; // byte store, loaded by the bench
    logic [3:0] cnt; // waits already spent on this read
    // restart the count after each answer so back-to-back reads also wait
    always_ff @(posedge clk) begin
        if (!req || valid) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    assign valid = req && (cnt >= waits);
    // inverted byte when not answering, so stale data never looks right
    assign data = valid ? mem[addr] : ~mem[addr];
endmodule // amd_mem_model

/* File: tb/addressing_mode_decoder_bench.sv */
`timescale 1ns/100ps
// self-checking bench: byte strings in, decoded results checked on done
module addressing_mode_decoder_bench;
    logic clk = 1'b0; // core clock
    logic rst = 1'b1; // reset, held ten cycles
    logic start = 1'b0; // decode request
    logic [15:0] start_pc = 16'h0000; // first byte address
    logic [7:0] idx_x = 8'h00; // x register
    logic [7:0] idx_y = 8'h00; // y register
    logic [3:0] waits = 4'h0; // memory wait states
    logic req, valid, busy, done, pfx, ysel; // handshake and flags
    logic [7:0] rdata, opc, oprnd; // byte outputs
    logic [15:0] addr, npc, ea, tgt; // address outputs
    logic [2:0] len; // instruction length
    amd_pkg::amd_mode_t mode; // decoded mode
    logic [73:0] expq [$]; // expected results, oldest first
    int errors = 0; // mismatches
    int checks = 0; // comparisons
    int seed = 32'h186d; // random seed
    logic [31:0] r; // random scratch
    int i; // loop index

    always #4 clk = ~clk;

    amd_addr_decoder u_dut (.clk(clk), .rst(rst), .start(start),
        .start_pc(start_pc), .idx_x(idx_x), .idx_y(idx_y),
        .mem_rd_data(rdata), .mem_rd_valid(valid), .mem_rd_req(req),
        .mem_addr(addr), .busy(busy), .done(done), .mode_out(mode),
        .opcode_out(opc), .prefixed(pfx), .y_sel(ysel), .instr_len(len),
        .next_pc(npc), .eff_addr(ea), .operand(oprnd),
        .branch_target(tgt));
    amd_mem_model u_mem (.clk(clk), .req(req), .addr(addr),
        .waits(waits), .data(rdata), .valid(valid));

    // one comparison, counted
    task automatic cmp(input logic [73:0] got, input logic [73:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // load code at a random pc, note the result, pulse start, await done
    task automatic run(input logic [31:0] code, input logic [2:0] n,
            input amd_pkg::amd_mode_t m, input logic [15:0] e,
            input logic [7:0] op);
        logic [15:0] pc;
        logic [15:0] np;
        logic pf; // first byte is a prefix
        int k;
        pc = 16'h1000 | (16'($random(seed)) & 16'h0fff);
        np = pc + 16'(n);
        for (k = 0; k < 4; k++) begin
            u_mem.mem[pc + 16'(k)] = code[31 - 8 * k -: 8];
        end
        pf = code[31:24] inside {8'h90, 8'h91, 8'h92};
        // prefixes 90 and 91 pick y; any non-immediate offset moves target
        expq.push_back({pf ? code[23:16] : code[31:24], pf,
            pf && !code[25], m, n, np, e, (m == amd_pkg::AMD_IMM) ?
            np : np + {{8{op[7]}}, op}, op});
        waits = 4'($random(seed)) & 4'h3;
        start_pc = pc;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        // bounded wait; running out counts as a mismatch
        for (k = 0; k < 200 && done !== 1'b1; k++) begin
            @(negedge clk);
        end
        if (done !== 1'b1) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, done, 1'b1);
        end
    endtask

    // result watcher: oldest note against whatever done presents
    always @(negedge clk) begin
        if (done === 1'b1) begin
            cmp({opc, pfx, ysel, mode, len, npc, ea, tgt, oprnd},
                expq.size() > 0 ? expq.pop_front() : 'x);
        end
    end

    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            run({4'(16'h4589 >> (12 - 4 * i)), 1'b1, r[2:0], 24'h0}, 3'd1,
                amd_pkg::AMD_INH, 16'h0, 8'h0);
        end
        // first pass all ones hits 1fe and the 16-bit wrap
        for (i = 0; i < 3; i++) begin
            r = (i == 0) ? 32'hffffffff : $random(seed);
            idx_x = r[7:0];
            idx_y = r[15:8];
            u_mem.mem[{8'h0, r[23:16]}] = r[31:24];
            u_mem.mem[{8'h0, r[23:16]} + 16'h1] = r[7:0];
            run({8'ha6, r[23:16], 16'h0}, 3'd2, amd_pkg::AMD_IMM, 16'h0,
                r[23:16]);
            run({8'hb6, r[23:16], 16'h0}, 3'd2, amd_pkg::AMD_DIR_S,
                {8'h0, r[23:16]}, 8'h0);
            run({8'hc6, r[31:16], 8'h0}, 3'd3, amd_pkg::AMD_DIR_L,
                r[31:16], 8'h0);
            run({8'hf6, 24'h0}, 3'd1, amd_pkg::AMD_IDX_0,
                {8'h0, idx_x}, 8'h0);
            run({16'h90f6, 16'h0}, 3'd2, amd_pkg::AMD_IDX_0,
                {8'h0, idx_y}, 8'h0);
            run({8'he6, r[23:16], 16'h0}, 3'd2, amd_pkg::AMD_IDX_S,
                {8'h0, r[23:16]} + idx_x, 8'h0);
            run({8'hd6, r[31:16], 8'h0}, 3'd3, amd_pkg::AMD_IDX_L,
                r[31:16] + idx_x, 8'h0);
            run({16'h92b6, r[23:16], 8'h0}, 3'd3, amd_pkg::AMD_IND_S,
                {8'h0, r[31:24]}, 8'h0);
            run({16'h92c6, r[23:16], 8'h0}, 3'd3, amd_pkg::AMD_IND_L,
                {r[31:24], r[7:0]}, 8'h0);
            run({16'h91e6, r[23:16], 8'h0}, 3'd3, amd_pkg::AMD_IIX_S,
                {8'h0, r[31:24]} + idx_y, 8'h0);
            run({8'h20, r[23:16], 16'h0}, 3'd2, amd_pkg::AMD_REL_D, 16'h0,
                r[23:16]);
            run({16'h91d6, r[23:16], 8'h0}, 3'd3, amd_pkg::AMD_IIX_L,
                {r[31:24], r[7:0]} + idx_y, 8'h0);
            run({16'h9200, r[23:16], r[15:8]}, 3'd4, amd_pkg::AMD_BITREL_I,
                {8'h0, r[31:24]}, r[15:8]);
            run({16'h92ad, r[23:16], 8'h0}, 3'd3, amd_pkg::AMD_REL_I, 16'h0,
                r[31:24]);
            run({8'h10, r[23:16], 16'h0}, 3'd2, amd_pkg::AMD_BIT_D,
                {8'h0, r[23:16]}, 8'h0);
            run({16'h90c6, r[31:16]}, 3'd4, amd_pkg::AMD_DIR_L,
                r[31:16], 8'h0);
        end
        repeat (4) @(negedge clk);
        if (expq.size() != 0) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time,
                expq.size(), 0);
        end
        tally_and_finish();
    end
endmodule // addressing_mode_decoder_bench
